/* src/lsba_alu.sv */
`timescale 1ns/10ps
// Summary of operation
// - And, or, exclusive or and complement on byte, word, long; result to destination.
// - Immediate variants combine an immediate operand with the destination.
// - Zero compare test sets flags from the operand and writes nothing back.
// - Arithmetic and logical shifts left and right on register or memory operands.
// - Plain rotates and rotates through the sticky carry bit.
// - Register shifts and rotates accept byte, word and long sizes.
// - A count held in the instruction shifts one to eight places.
// - A count taken from a data register is used modulo 64.
// - Memory shifts work on words and move exactly one place.
// - Half swap exchanges the upper and lower 16-bit halves.
// - Rotate by eight finishes in one cycle for fast byte swapping.
// - Single-bit operations load the inverted selected bit into zero flag.
// - Then set, clear or flip the bit; plain test leaves it alone.
// - Bit number comes from immediate data or a data register.
// - Single-bit register operands are 32 bits, memory operands 8 bits.
// - Bit fields are given by offset and width of 1 to 32 bits.
// - Insert writes the field; extracts zero or sign extend it.
// - First one scan writes offset of the first set field bit.
// - Field clear writes zeros, fill writes ones, flip inverts.
// - Field operations set N from field top bit, Z when field is zero.
// - Decimal add, subtract and negate on bytes including sticky carry.
// - Pack adds immediate to 16-bit source giving a byte; unpack expands then adds.
module lsba_alu (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Request
  input wire logic req_i,
  input wire logic [4:0] op_i,
  input wire logic [1:0] size_i,
  input wire logic mem_i,
  input wire logic use_imm_i,
  input wire logic cnt_reg_i,
  // Operands
  input wire logic [31:0] src_i,
  input wire logic [31:0] imm_i,
  input wire logic [31:0] dst_i,
  input wire logic [31:0] count_i,
  input wire logic [31:0] bf_off_i,
  input wire logic [4:0] bf_width_i,
  input wire logic [4:0] ccr_i,
  // Answer
  output logic done_o,
  output logic wr_o,
  output logic [31:0] result_o,
  output logic [4:0] ccr_o
);

  typedef struct packed {
    logic rs1;
    logic rs2;
    logic done;
    logic wr;
    logic [31:0] res;
    logic [4:0] ccr;
  } lsba_state_t;

  lsba_state_t st_r;
  lsba_state_t st_nxt;
  logic [1:0] sz;
  logic [4:0] m;
  logic [31:0] mk;
  logic [31:0] a;
  logic [31:0] lr;
  logic [31:0] res;
  logic [4:0] c;
  logic wr;
  logic [5:0] cnt;
  logic [31:0] v;
  logic [31:0] nv;
  logic x;
  logic ob;
  logic fb;
  logic ov;
  logic left;
  logic [4:0] bn;
  logic [31:0] bm;
  logic [5:0] wv;
  logic [31:0] r;
  logic [31:0] tm;
  logic [31:0] fm;
  logic [31:0] fld;
  logic [31:0] rm;
  logic [5:0] p;
  logic [7:0] bd;
  logic [7:0] bs;
  logic [4:0] lo;
  logic [4:0] hi;
  logic bcy;
  logic [15:0] t;

  function automatic logic [31:0] lsba_rotl(input logic [31:0] val, input logic [4:0] amt);
    return (val << amt) | (val >> (6'h20 - {1'h0, amt}));
  endfunction : lsba_rotl

  function automatic logic [31:0] lsba_rotr(input logic [31:0] val, input logic [4:0] amt);
    return (val >> amt) | (val << (6'h20 - {1'h0, amt}));
  endfunction : lsba_rotr

  function automatic logic [4:0] lsba_msb(input logic [1:0] s);
    return (s == lsba_pkg::SZ_BYTE) ? 5'h07 : (s == lsba_pkg::SZ_WORD) ? 5'h0F : 5'h1F;
  endfunction : lsba_msb

  function automatic logic [31:0] lsba_mask(input logic [1:0] s);
    return (s == lsba_pkg::SZ_BYTE) ? 32'h0000_00FF :
           (s == lsba_pkg::SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  endfunction : lsba_mask

  ////////////////////////////////////////////////////////////////////////////////
  // Every operation is a single combinational pass, so rotate by eight costs
  // the same one cycle as any other; the price is a wide unrolled shifter.
  always_comb begin
    st_nxt = st_r;
    left = (op_i == lsba_pkg::OP_ARITH_SHIFT_LEFT) || (op_i == lsba_pkg::OP_LOGIC_SHIFT_LEFT) ||
           (op_i == lsba_pkg::OP_ROTATE_LEFT) || (op_i == lsba_pkg::OP_ROTATE_LEFT_THRU_EXTEND);
    sz = (mem_i && op_i >= lsba_pkg::OP_ARITH_SHIFT_LEFT &&
          op_i <= lsba_pkg::OP_ROTATE_RIGHT_THRU_EXTEND) ? lsba_pkg::SZ_WORD : size_i;
    m = lsba_msb(sz);
    mk = lsba_mask(sz);
    a = use_imm_i ? imm_i : src_i;
    res = dst_i;
    c = ccr_i;
    wr = 1'h1;
    lr = 32'h0000_0000;
    if (mem_i) begin
      cnt = lsba_pkg::MEM_SHIFT_CNT;
    end else if (cnt_reg_i) begin
      cnt = count_i[5:0];
    end else begin
      cnt = (count_i[2:0] == 3'h0) ? lsba_pkg::IMM_CNT_ZERO_AS : {3'h0, count_i[2:0]};
    end
    v = dst_i & mk;
    nv = v;
    x = ccr_i[lsba_pkg::CCR_X];
    ob = 1'h0;
    fb = 1'h0;
    ov = 1'h0;
    bn = mem_i ? {2'h0, a[2:0]} : a[4:0];
    bm = 32'h0000_0001 << bn;
    wv = (bf_width_i == 5'h00) ? lsba_pkg::FIELD_FULL_W : {1'h0, bf_width_i};
    r = lsba_rotl(dst_i, bf_off_i[4:0]);
    tm = ~(32'hFFFF_FFFF >> wv);
    fm = lsba_rotr(tm, bf_off_i[4:0]);
    fld = r >> (6'h20 - wv);
    rm = r & tm;
    p = wv;
    bs = (op_i == lsba_pkg::OP_DECIMAL_NEGATE_EXTEND) ? dst_i[7:0] : src_i[7:0];
    bd = (op_i == lsba_pkg::OP_DECIMAL_NEGATE_EXTEND) ? 8'h00 : dst_i[7:0];
    lo = 5'h00;
    hi = 5'h00;
    bcy = 1'h0;
    t = 16'h0000;
    unique case (op_i)
      lsba_pkg::OP_AND, lsba_pkg::OP_OR, lsba_pkg::OP_XOR, lsba_pkg::OP_NOT,
      lsba_pkg::OP_ZERO_COMPARE_TEST: begin
        unique case (op_i)
          lsba_pkg::OP_AND: lr = a & dst_i;
          lsba_pkg::OP_OR: lr = a | dst_i;
          lsba_pkg::OP_XOR: lr = a ^ dst_i;
          lsba_pkg::OP_NOT: lr = ~dst_i;
          default: lr = dst_i;
        endcase
        lr = lr & mk;
        res = (dst_i & ~mk) | lr;
        wr = (op_i != lsba_pkg::OP_ZERO_COMPARE_TEST);
        c[lsba_pkg::CCR_N] = lr[m];
        c[lsba_pkg::CCR_Z] = (lr == 32'h0000_0000);
        c[lsba_pkg::CCR_V] = 1'h0;
        c[lsba_pkg::CCR_C] = 1'h0;
      end
      lsba_pkg::OP_ARITH_SHIFT_LEFT, lsba_pkg::OP_ARITH_SHIFT_RIGHT,
      lsba_pkg::OP_LOGIC_SHIFT_LEFT, lsba_pkg::OP_LOGIC_SHIFT_RIGHT,
      lsba_pkg::OP_ROTATE_LEFT, lsba_pkg::OP_ROTATE_RIGHT,
      lsba_pkg::OP_ROTATE_LEFT_THRU_EXTEND, lsba_pkg::OP_ROTATE_RIGHT_THRU_EXTEND: begin
        for (int i = 0; i < 63; i++) begin
          if (6'(i) < cnt) begin
            if (left) begin
              ob = v[m];
              fb = (op_i == lsba_pkg::OP_ROTATE_LEFT) ? v[m] :
                   (op_i == lsba_pkg::OP_ROTATE_LEFT_THRU_EXTEND) ? x : 1'h0;
              nv = ((v << 1) | {31'h0000_0000, fb}) & mk;
              ov = ov | (nv[m] ^ v[m]);
            end else begin
              ob = v[0];
              fb = (op_i == lsba_pkg::OP_ARITH_SHIFT_RIGHT) ? v[m] :
                   (op_i == lsba_pkg::OP_ROTATE_RIGHT) ? v[0] :
                   (op_i == lsba_pkg::OP_ROTATE_RIGHT_THRU_EXTEND) ? x : 1'h0;
              nv = (v >> 1) | ({31'h0000_0000, fb} << m);
            end
            v = nv;
            if (op_i != lsba_pkg::OP_ROTATE_LEFT && op_i != lsba_pkg::OP_ROTATE_RIGHT) begin
              x = ob;
            end
          end
        end
        res = (dst_i & ~mk) | v;
        c[lsba_pkg::CCR_X] = x;
        c[lsba_pkg::CCR_N] = v[m];
        c[lsba_pkg::CCR_Z] = (v == 32'h0000_0000);
        c[lsba_pkg::CCR_V] = (op_i == lsba_pkg::OP_ARITH_SHIFT_LEFT) ? ov : 1'h0;
        if (cnt == 6'h00) begin
          c[lsba_pkg::CCR_C] = (op_i == lsba_pkg::OP_ROTATE_LEFT_THRU_EXTEND ||
                                op_i == lsba_pkg::OP_ROTATE_RIGHT_THRU_EXTEND) ? x : 1'h0;
        end else begin
          c[lsba_pkg::CCR_C] = ob;
        end
      end
      lsba_pkg::OP_HALF_SWAP: begin
        res = {dst_i[15:0], dst_i[31:16]};
        c[lsba_pkg::CCR_N] = dst_i[15];
        c[lsba_pkg::CCR_Z] = (dst_i == 32'h0000_0000);
        c[lsba_pkg::CCR_V] = 1'h0;
        c[lsba_pkg::CCR_C] = 1'h0;
      end
      lsba_pkg::OP_SINGLE_BIT_TEST, lsba_pkg::OP_SINGLE_BIT_SET_TEST,
      lsba_pkg::OP_SINGLE_BIT_CLEAR_TEST, lsba_pkg::OP_SINGLE_BIT_FLIP_TEST: begin
        c[lsba_pkg::CCR_Z] = ~|(dst_i & bm);
        unique case (op_i)
          lsba_pkg::OP_SINGLE_BIT_SET_TEST: res = dst_i | bm;
          lsba_pkg::OP_SINGLE_BIT_CLEAR_TEST: res = dst_i & ~bm;
          lsba_pkg::OP_SINGLE_BIT_FLIP_TEST: res = dst_i ^ bm;
          default: wr = 1'h0;
        endcase
      end
      lsba_pkg::OP_FIELD_FLIP, lsba_pkg::OP_FIELD_CLEAR, lsba_pkg::OP_FIELD_EXTRACT_SIGNED,
      lsba_pkg::OP_FIELD_EXTRACT_UNSIGNED, lsba_pkg::OP_FIELD_FIRST_ONE_SCAN,
      lsba_pkg::OP_FIELD_INSERT, lsba_pkg::OP_FIELD_FILL_ONES, lsba_pkg::OP_FIELD_TEST: begin
        // Flags come from the field as it stood before the operation.
        c[lsba_pkg::CCR_N] = r[31];
        c[lsba_pkg::CCR_Z] = (rm == 32'h0000_0000);
        c[lsba_pkg::CCR_V] = 1'h0;
        c[lsba_pkg::CCR_C] = 1'h0;
        for (int i = 0; i < 32; i++) begin
          if (rm[i]) begin
            p = 6'(31 - i);
          end
        end
        unique case (op_i)
          lsba_pkg::OP_FIELD_FLIP: res = dst_i ^ fm;
          lsba_pkg::OP_FIELD_CLEAR: res = dst_i & ~fm;
          lsba_pkg::OP_FIELD_FILL_ONES: res = dst_i | fm;
          lsba_pkg::OP_FIELD_INSERT:
            res = (dst_i & ~fm) | (lsba_rotr(src_i << (6'h20 - wv), bf_off_i[4:0]) & fm);
          lsba_pkg::OP_FIELD_EXTRACT_UNSIGNED: res = fld;
          lsba_pkg::OP_FIELD_EXTRACT_SIGNED:
            res = r[31] ? (fld | ~(32'hFFFF_FFFF >> (6'h20 - wv))) : fld;
          lsba_pkg::OP_FIELD_FIRST_ONE_SCAN: res = bf_off_i + {26'h000_0000, p};
          default: wr = 1'h0;
        endcase
      end
      lsba_pkg::OP_DECIMAL_ADD_EXTEND: begin
        lo = {1'h0, bd[3:0]} + {1'h0, bs[3:0]} + {4'h0, x};
        if (lo > lsba_pkg::BCD_MAX_DIGIT) begin
          lo = lo + lsba_pkg::BCD_ADJUST;
        end
        hi = {1'h0, bd[7:4]} + {1'h0, bs[7:4]} + {4'h0, lo[4]};
        bcy = (hi > lsba_pkg::BCD_MAX_DIGIT);
        if (bcy) begin
          hi = hi + lsba_pkg::BCD_ADJUST;
        end
      end
      lsba_pkg::OP_DECIMAL_SUB_EXTEND, lsba_pkg::OP_DECIMAL_NEGATE_EXTEND: begin
        lo = {1'h0, bd[3:0]} - {1'h0, bs[3:0]} - {4'h0, x};
        if (lo[4]) begin
          lo = lo - lsba_pkg::BCD_ADJUST;
        end
        hi = {1'h0, bd[7:4]} - {1'h0, bs[7:4]} - {4'h0, lo[4]};
        bcy = hi[4];
        if (bcy) begin
          hi = hi - lsba_pkg::BCD_ADJUST;
        end
      end
      lsba_pkg::OP_DECIMAL_PACK: begin
        t = src_i[15:0] + imm_i[15:0];
        res = {dst_i[31:8], t[11:8], t[3:0]};
      end
      lsba_pkg::OP_DECIMAL_UNPACK: begin
        t = {4'h0, src_i[7:4], 4'h0, src_i[3:0]} + imm_i[15:0];
        res = {dst_i[31:16], t};
      end
      default: begin
        wr = 1'h0;
      end
    endcase
    if (op_i >= lsba_pkg::OP_DECIMAL_ADD_EXTEND && op_i <= lsba_pkg::OP_DECIMAL_NEGATE_EXTEND) begin
      // Zero flag only clears, so a multi-byte string tests zero as a whole.
      res = {dst_i[31:8], hi[3:0], lo[3:0]};
      c[lsba_pkg::CCR_X] = bcy;
      c[lsba_pkg::CCR_C] = bcy;
      c[lsba_pkg::CCR_N] = hi[3];
      if ({hi[3:0], lo[3:0]} != 8'h00) begin
        c[lsba_pkg::CCR_Z] = 1'h0;
      end
    end
    st_nxt.rs1 = 1'h1;
    st_nxt.rs2 = st_r.rs1;
    st_nxt.done = req_i;
    st_nxt.wr = req_i & wr;
    if (req_i) begin
      st_nxt.res = res;
      st_nxt.ccr = c;
    end
    if (!st_r.rs2) begin
      st_nxt.done = 1'h0;
      st_nxt.wr = 1'h0;
      st_nxt.res = lsba_pkg::RESULT_RST;
      st_nxt.ccr = lsba_pkg::CCR_RST;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '{1'h0, 1'h0, 1'h0, 1'h0, lsba_pkg::RESULT_RST, lsba_pkg::CCR_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_o = st_r.done;
  assign wr_o = st_r.wr;
  assign result_o = st_r.res;
  assign ccr_o = st_r.ccr;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!st_r.rs2);

  property p_logic_flags;
    $past(req_i) && $past(op_i) <= lsba_pkg::OP_ZERO_COMPARE_TEST |->
      !ccr_o[lsba_pkg::CCR_V] && !ccr_o[lsba_pkg::CCR_C] &&
      ccr_o[lsba_pkg::CCR_X] == $past(ccr_i[lsba_pkg::CCR_X]);
  endproperty
  a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong");
  property p_and_long;
    $past(req_i) && $past(op_i) == lsba_pkg::OP_AND && $past(size_i) == lsba_pkg::SZ_LONG &&
      !$past(use_imm_i) |-> wr_o && result_o == ($past(src_i) & $past(dst_i));
  endproperty
  a_and_long: assert property (p_and_long) else $error("and result wrong");
  property p_xori_byte;
    $past(req_i) && $past(op_i) == lsba_pkg::OP_XOR && $past(size_i) == lsba_pkg::SZ_BYTE &&
      $past(use_imm_i) |->
      result_o == {$past(dst_i[31:8]), $past(imm_i[7:0]) ^ $past(dst_i[7:0])};
  endproperty
  a_xori_byte: assert property (p_xori_byte) else $error("immediate xor wrong");
  property p_test_nowrite;
    req_i && op_i == lsba_pkg::OP_ZERO_COMPARE_TEST ##1 done_o |-> !wr_o;
  endproperty
  a_test_nowrite: assert property (p_test_nowrite) else $error("test wrote back");
  property p_swap;
    $past(req_i) && $past(op_i) == lsba_pkg::OP_HALF_SWAP |->
      result_o == {$past(dst_i[15:0]), $past(dst_i[31:16])};
  endproperty
  a_swap: assert property (p_swap) else $error("half swap wrong");
  property p_rol8;
    $past(req_i) && $past(op_i) == lsba_pkg::OP_ROTATE_LEFT && !$past(mem_i) &&
      !$past(cnt_reg_i) && $past(count_i[2:0]) == 3'h0 && $past(size_i) == lsba_pkg::SZ_LONG
      |-> done_o && result_o == {$past(dst_i[23:0]), $past(dst_i[31:24])};
  endproperty
  a_rol8: assert property (p_rol8) else $error("rotate by eight wrong");
  property p_mod64;
    $past(req_i) && $past(op_i) == lsba_pkg::OP_LOGIC_SHIFT_LEFT && !$past(mem_i) &&
      $past(cnt_reg_i) && $past(count_i[5:0]) == 6'h00 |->
      result_o == $past(dst_i) && !ccr_o[lsba_pkg::CCR_C];
  endproperty
  a_mod64: assert property (p_mod64) else $error("count not modulo 64");
  property p_mem_lsr;
    $past(req_i) && $past(op_i) == lsba_pkg::OP_LOGIC_SHIFT_RIGHT && $past(mem_i) |->
      result_o[15:0] == {1'h0, $past(dst_i[15:1])} &&
      ccr_o[lsba_pkg::CCR_C] == $past(dst_i[0]) && ccr_o[lsba_pkg::CCR_X] == $past(dst_i[0]);
  endproperty
  a_mem_lsr: assert property (p_mem_lsr) else $error("memory shift wrong");
  property p_bit_z;
    $past(req_i) && $past(op_i) >= lsba_pkg::OP_SINGLE_BIT_TEST &&
      $past(op_i) <= lsba_pkg::OP_SINGLE_BIT_FLIP_TEST && !$past(mem_i) && !$past(use_imm_i)
      |-> ccr_o[lsba_pkg::CCR_Z] == !$past(dst_i[src_i[4:0]]);
  endproperty
  a_bit_z: assert property (p_bit_z) else $error("bit zero flag wrong");
  property p_bit_set;
    $past(req_i) && $past(op_i) == lsba_pkg::OP_SINGLE_BIT_SET_TEST && !$past(mem_i) &&
      !$past(use_imm_i) |-> result_o == ($past(dst_i) | (32'h0000_0001 << $past(src_i[4:0])));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");
  property p_field_n;
    $past(req_i) && $past(op_i) >= lsba_pkg::OP_FIELD_FLIP &&
      $past(op_i) <= lsba_pkg::OP_FIELD_TEST && $past(bf_off_i[4:0]) == 5'h00 |->
      ccr_o[lsba_pkg::CCR_N] == $past(dst_i[31]);
  endproperty
  a_field_n: assert property (p_field_n) else $error("field negative flag wrong");

  c_rol8: cover property (req_i && op_i == lsba_pkg::OP_ROTATE_LEFT ##1 done_o);
  c_bit_flip: cover property (req_i && op_i == lsba_pkg::OP_SINGLE_BIT_FLIP_TEST ##1 wr_o);
  c_bcd_carry: cover property (req_i && op_i == lsba_pkg::OP_DECIMAL_ADD_EXTEND ##1
    ccr_o[lsba_pkg::CCR_C]);
  c_scan: cover property (req_i && op_i == lsba_pkg::OP_FIELD_FIRST_ONE_SCAN ##1 done_o);

endmodule : lsba_alu

/* src/lsba_pkg.sv */
package lsba_pkg;
  localparam int DATA_W = 32;
  localparam int CCR_W = 5;
  // Operation codes presented on op_i.
  localparam logic [4:0] OP_AND = 5'h00;
  localparam logic [4:0] OP_OR = 5'h01;
  localparam logic [4:0] OP_XOR = 5'h02;
  localparam logic [4:0] OP_NOT = 5'h03;
  localparam logic [4:0] OP_ZERO_COMPARE_TEST = 5'h04;
  localparam logic [4:0] OP_ARITH_SHIFT_LEFT = 5'h05;
  localparam logic [4:0] OP_ARITH_SHIFT_RIGHT = 5'h06;
  localparam logic [4:0] OP_LOGIC_SHIFT_LEFT = 5'h07;
  localparam logic [4:0] OP_LOGIC_SHIFT_RIGHT = 5'h08;
  localparam logic [4:0] OP_ROTATE_LEFT = 5'h09;
  localparam logic [4:0] OP_ROTATE_RIGHT = 5'h0A;
  localparam logic [4:0] OP_ROTATE_LEFT_THRU_EXTEND = 5'h0B;
  localparam logic [4:0] OP_ROTATE_RIGHT_THRU_EXTEND = 5'h0C;
  localparam logic [4:0] OP_HALF_SWAP = 5'h0D;
  localparam logic [4:0] OP_SINGLE_BIT_TEST = 5'h0E;
  localparam logic [4:0] OP_SINGLE_BIT_SET_TEST = 5'h0F;
  localparam logic [4:0] OP_SINGLE_BIT_CLEAR_TEST = 5'h10;
  localparam logic [4:0] OP_SINGLE_BIT_FLIP_TEST = 5'h11;
  localparam logic [4:0] OP_FIELD_FLIP = 5'h12;
  localparam logic [4:0] OP_FIELD_CLEAR = 5'h13;
  localparam logic [4:0] OP_FIELD_EXTRACT_SIGNED = 5'h14;
  localparam logic [4:0] OP_FIELD_EXTRACT_UNSIGNED = 5'h15;
  localparam logic [4:0] OP_FIELD_FIRST_ONE_SCAN = 5'h16;
  localparam logic [4:0] OP_FIELD_INSERT = 5'h17;
  localparam logic [4:0] OP_FIELD_FILL_ONES = 5'h18;
  localparam logic [4:0] OP_FIELD_TEST = 5'h19;
  localparam logic [4:0] OP_DECIMAL_ADD_EXTEND = 5'h1A;
  localparam logic [4:0] OP_DECIMAL_SUB_EXTEND = 5'h1B;
  localparam logic [4:0] OP_DECIMAL_NEGATE_EXTEND = 5'h1C;
  localparam logic [4:0] OP_DECIMAL_PACK = 5'h1D;
  localparam logic [4:0] OP_DECIMAL_UNPACK = 5'h1E;
  // Operand sizes presented on size_i.
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // Condition flag positions in ccr_i and ccr_o.
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_X = 4;
  // Reset values.
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [4:0] CCR_RST = 5'h00;
  // Counts and decimal constants.
  localparam logic [5:0] IMM_CNT_ZERO_AS = 6'h08;
  localparam logic [5:0] MEM_SHIFT_CNT = 6'h01;
  localparam logic [5:0] FIELD_FULL_W = 6'h20;
  localparam logic [4:0] BCD_MAX_DIGIT = 5'h09;
  localparam logic [4:0] BCD_ADJUST = 5'h06;
endpackage : lsba_pkg

/* tb/lsba_alu_tb_top.sv */
`timescale 1ns/10ps
module lsba_alu_tb_top;
  logic clk_i;
  logic reset_n_i;
  logic req_i;
  logic [4:0] op_i;
  logic [1:0] size_i;
  logic mem_i;
  logic use_imm_i;
  logic cnt_reg_i;
  logic [31:0] src_i;
  logic [31:0] imm_i;
  logic [31:0] dst_i;
  logic [31:0] count_i;
  logic [31:0] bf_off_i;
  logic [4:0] bf_width_i;
  logic [4:0] ccr_i;
  logic done_o;
  logic wr_o;
  logic [31:0] result_o;
  logic [4:0] ccr_o;
  int n_errors;
  int check_count;

  lsba_alu dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .op_i(op_i),
    .size_i(size_i), .mem_i(mem_i), .use_imm_i(use_imm_i), .cnt_reg_i(cnt_reg_i),
    .src_i(src_i), .imm_i(imm_i), .dst_i(dst_i), .count_i(count_i), .bf_off_i(bf_off_i),
    .bf_width_i(bf_width_i), .ccr_i(ccr_i), .done_o(done_o), .wr_o(wr_o),
    .result_o(result_o), .ccr_o(ccr_o));

  always #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // One operation: present at a falling edge, answer is due one clock later.
  // Result is only compared when write-back is expected; test ops leave it open.
  task automatic go(input logic [4:0] o, input logic [31:0] d, input logic [31:0] s,
      input logic [4:0] ci, input logic [31:0] er, input logic [4:0] ec, input logic ew);
    @(negedge clk_i);
    op_i = o;
    dst_i = d;
    src_i = s;
    ccr_i = ci;
    req_i = 1'b1;
    @(negedge clk_i);
    req_i = 1'b0;
    chk(done_o, 1'b1);
    chk(wr_o, ew);
    chk(ccr_o, ec);
    if (ew) begin
      chk(result_o, er);
    end
  endtask : go

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    req_i = 1'b0;
    op_i = 5'h00;
    size_i = lsba_pkg::SZ_LONG;
    {mem_i, use_imm_i, cnt_reg_i} = 3'h0;
    {src_i, imm_i, dst_i, count_i, bf_off_i} = '0;
    bf_width_i = 5'h00;
    ccr_i = 5'h00;
    n_errors = 0;
    check_count = 0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    // A request while the internal reset copy is still low must be dropped.
    req_i = 1'b1;
    chk(done_o, 1'b0);
    chk(result_o, lsba_pkg::RESULT_RST);
    @(negedge clk_i);
    req_i = 1'b0;
    chk(done_o, 1'b0);
    chk(wr_o, 1'b0);
    chk(ccr_o, lsba_pkg::CCR_RST);
    repeat (2) @(negedge clk_i);
    go(lsba_pkg::OP_AND, 32'h3C, 32'hF0, 5'h10, 32'h30, 5'h10, 1'b1);
    go(lsba_pkg::OP_NOT, 32'hFFFF_FFFF, 32'h0, 5'h03, 32'h0, 5'h04, 1'b1);
    size_i = lsba_pkg::SZ_BYTE;
    go(lsba_pkg::OP_OR, 32'h1234_5680, 32'hF, 5'h03, 32'h1234_568F, 5'h08, 1'b1);
    go(lsba_pkg::OP_ZERO_COMPARE_TEST, 32'h80, 32'h0, 5'h1F, 32'h0, 5'h18, 1'b0);
    size_i = lsba_pkg::SZ_WORD;
    use_imm_i = 1'b1;
    imm_i = 32'hFFFF;
    go(lsba_pkg::OP_XOR, 32'hAAAA_5555, 32'h0, 5'h00, 32'hAAAA_AAAA, 5'h08, 1'b1);
    size_i = lsba_pkg::SZ_BYTE;
    go(lsba_pkg::OP_XOR, 32'h1234_56F0, 32'h0, 5'h00, 32'h1234_560F, 5'h00, 1'b1);
    use_imm_i = 1'b0;
    size_i = lsba_pkg::SZ_LONG;
    go(lsba_pkg::OP_LOGIC_SHIFT_RIGHT, 32'h8000_0080, 0, 0, 32'h0080_0000, 5'h11, 1);
    go(lsba_pkg::OP_ROTATE_LEFT, 32'h1234_5678, 0, 5'h10, 32'h3456_7812, 5'h10, 1);
    go(lsba_pkg::OP_HALF_SWAP, 32'h1234_5678, 0, 5'h00, 32'h5678_1234, 5'h00, 1);
    cnt_reg_i = 1'b1;
    count_i = 32'h1;
    go(lsba_pkg::OP_ARITH_SHIFT_LEFT, 32'h4000_0000, 0, 0, 32'h8000_0000, 5'h0A, 1);
    size_i = lsba_pkg::SZ_BYTE;
    count_i = 32'h41;
    go(lsba_pkg::OP_LOGIC_SHIFT_LEFT, 32'h81, 0, 0, 32'h02, 5'h11, 1);
    count_i = 32'h40;
    go(lsba_pkg::OP_LOGIC_SHIFT_LEFT, 32'h81, 0, 5'h10, 32'h81, 5'h18, 1);
    count_i = 32'h41;
    cnt_reg_i = 1'b0;
    go(lsba_pkg::OP_ROTATE_LEFT_THRU_EXTEND, 32'h80, 0, 5'h10, 32'h01, 5'h11, 1);
    go(lsba_pkg::OP_ROTATE_RIGHT_THRU_EXTEND, 32'h01, 0, 0, 32'h00, 5'h15, 1);
    size_i = lsba_pkg::SZ_WORD;
    count_i = 32'h0;
    go(lsba_pkg::OP_ROTATE_RIGHT, 32'hABCD, 0, 5'h00, 32'hCDAB, 5'h09, 1);
    mem_i = 1'b1;
    go(lsba_pkg::OP_ARITH_SHIFT_RIGHT, 32'h8001, 0, 0, 32'hC000, 5'h19, 1);
    go(lsba_pkg::OP_LOGIC_SHIFT_RIGHT, 32'hFFFF_8001, 0, 0, 32'hFFFF_4000, 5'h11, 1);
    mem_i = 1'b0;
    go(lsba_pkg::OP_SINGLE_BIT_TEST, 32'h10, 32'h24, 0, 32'h10, 5'h00, 0);
    go(lsba_pkg::OP_SINGLE_BIT_SET_TEST, 32'h10, 32'h24, 0, 32'h10, 5'h00, 1);
    go(lsba_pkg::OP_SINGLE_BIT_CLEAR_TEST, 32'h10, 32'h24, 0, 32'h0, 5'h00, 1);
    go(lsba_pkg::OP_SINGLE_BIT_FLIP_TEST, 32'h10, 32'h24, 0, 32'h0, 5'h00, 1);
    use_imm_i = 1'b1;
    imm_i = 32'h5;
    go(lsba_pkg::OP_SINGLE_BIT_SET_TEST, 32'h0, 32'h0, 0, 32'h20, 5'h04, 1);
    use_imm_i = 1'b0;
    mem_i = 1'b1;
    go(lsba_pkg::OP_SINGLE_BIT_FLIP_TEST, 32'h20, 32'hD, 0, 32'h0, 5'h00, 1);
    mem_i = 1'b0;
    bf_width_i = 5'h08;
    go(lsba_pkg::OP_FIELD_EXTRACT_UNSIGNED, 32'hA512_3456, 0, 5'h10, 32'hA5, 5'h18, 1);
    go(lsba_pkg::OP_FIELD_EXTRACT_SIGNED, 32'hA512_3456, 0, 5'h10, 32'hFFFF_FFA5, 5'h18, 1);
    go(lsba_pkg::OP_FIELD_INSERT, 32'hA512_3456, 32'h13C, 5'h10, 32'h3C12_3456, 5'h18, 1);
    go(lsba_pkg::OP_FIELD_CLEAR, 32'hA512_3456, 0, 5'h10, 32'h0012_3456, 5'h18, 1);
    go(lsba_pkg::OP_FIELD_FILL_ONES, 32'hA512_3456, 0, 5'h10, 32'hFF12_3456, 5'h18, 1);
    go(lsba_pkg::OP_FIELD_FLIP, 32'hA512_3456, 0, 5'h10, 32'h5A12_3456, 5'h18, 1);
    go(lsba_pkg::OP_FIELD_TEST, 32'hA512_3456, 0, 5'h10, 32'h0, 5'h18, 0);
    bf_off_i = 32'h4;
    go(lsba_pkg::OP_FIELD_FIRST_ONE_SCAN, 32'hA512_3456, 0, 5'h10, 32'h5, 5'h10, 1);
    // An offset near the end makes the field wrap round from bit 0 to bit 31.
    bf_off_i = 32'h1C;
    go(lsba_pkg::OP_FIELD_EXTRACT_UNSIGNED, 32'hF, 0, 5'h00, 32'hF0, 5'h08, 1);
    bf_off_i = 32'h0;
    bf_width_i = 5'h00;
    go(lsba_pkg::OP_FIELD_EXTRACT_UNSIGNED, 32'h0, 0, 5'h10, 32'h0, 5'h14, 1);
    size_i = lsba_pkg::SZ_BYTE;
    go(lsba_pkg::OP_DECIMAL_ADD_EXTEND, 32'h28, 32'h19, 5'h14, 32'h48, 5'h00, 1);
    go(lsba_pkg::OP_DECIMAL_ADD_EXTEND, 32'h99, 32'h01, 5'h04, 32'h00, 5'h15, 1);
    go(lsba_pkg::OP_DECIMAL_SUB_EXTEND, 32'h10, 32'h01, 5'h10, 32'h08, 5'h00, 1);
    go(lsba_pkg::OP_DECIMAL_NEGATE_EXTEND, 32'h01, 32'h0, 5'h00, 32'h99, 5'h19, 1);
    imm_i = 32'h302;
    go(lsba_pkg::OP_DECIMAL_PACK, 32'hFFFF_FF00, 32'h304, 5'h0A, 32'hFFFF_FF66, 5'h0A, 1);
    imm_i = 32'h3030;
    go(lsba_pkg::OP_DECIMAL_UNPACK, 32'hFFFF_0000, 32'h12, 5'h0A, 32'hFFFF_3132, 5'h0A, 1);
    repeat (2) @(negedge clk_i);
    chk(done_o, 1'b0);
    final_report();
  end
endmodule : lsba_alu_tb_top
